// >>> rtl/dfpi_defines.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * decimating filter pin interface.
 * Assumes byte addressing on a 32-bit APB, one register per word.
 */
`ifndef DFPI_DEFINES_SVH
`define DFPI_DEFINES_SVH

// Control register indices (two select lines) and byte offsets
`define DFPI_IDX_FILTER_CTL   2'h0
`define DFPI_IDX_COEF_WORD    2'h1
`define DFPI_IDX_DECIM_STAGE  2'h2
`define DFPI_IDX_DECIM_RATE   2'h3
`define DFPI_OFF_SAMPLE_DIV   8'h10
`define DFPI_OFF_STATUS       8'h14
`define DFPI_OFF_CTL_LAST     8'h0C

// Field positions
`define DFPI_FDIS_BIT         0
`define DFPI_FBYP_BIT         1
`define DFPI_STAGE_W          3
`define DFPI_STAT_RUN_BIT     0
`define DFPI_STAT_OVR_BIT     1
`define DFPI_STAT_LVL_LSB     8

// Reset values
`define DFPI_FILTER_CTL_RST   16'h0001
`define DFPI_CTL_ZERO_RST     16'h0000
`define DFPI_PIN_RST          5'h1F

// Timing
`define DFPI_PCLK_HZ          25000000
`define DFPI_SAMPLE_MAX_HZ    33000000
`define DFPI_TAP_MAX_HZ       33000000

// Result word: position of weight 2^0 in the accumulator
`define DFPI_ACC_W            40
`define DFPI_W0_BIT           31

`endif

// >>> rtl/dfpi_pkg.sv
/*
 * Types of the decimating filter pin interface.
 * Assumes dfpi_defines.svh carries all numbers.
 */
package dfpi_pkg;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } dfpi_run_t;

    // Order of the synchronised pins
    typedef enum int {
        PIN_ASTART = 0,
        PIN_SSTART = 1,
        PIN_USEL   = 2,
        PIN_LOEN   = 3,
        PIN_UOEN   = 4
    } dfpi_pin_t;

endpackage : dfpi_pkg

// >>> rtl/dfpi_top.sv
/*
 * Pin interface of a two-stage decimating filter: sample capture, control
 * registers over APB, start logic, decimation enable, result FIFO, output
 * byte selection and output enables. Holds dfpi_fifo and dfpi_top.
 * Assumes one clock pclk; the tap filter rate equals pclk and the sample
 * rate is divided from it. Pins are synchronised inside.
 */
// Contract
// - Decimator work happens only on the sample-clock enable, at most 33 MHz.
// - Tap filter rate is pclk; sample rate divided from it, synchronous.
// - Source gives 16-bit samples synchronously; captured on sample enable.
// - Write with select and strobe loads the addressed control register.
// - 24-bit result; lower 16 bits weight 2^0 or 2^-16 by bypass.
// - Upper byte weights 2^8..2^1 if select high, else 2^-16..2^-23.
// - Lower 16 bits driven while their low-active enable is low.
// - Upper 8 bits driven while their own low-active enable is low.
// - High strobe marks a fresh result on the output bus.
// - Reset stops the divider, clears decimator registers, not the FIR path; the code also resets the FIFO and the tap filter stage.
// - Reset clears bypass, stage count and rate, and sets filter disable.
// - Async start is synchronised, starts operation, makes the start pulse.
// - Start output pulse is low exactly one sample period.
// - Falling edge of the synchronous start, sampled, starts the device.
// - Decimation enable stays idle after reset until start.

`include "dfpi_defines.svh"

module dfpi_fifo #(
    parameter int W = 40,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data,
    // Fill level
    output logic [$clog2(D):0] level
);
    localparam int AW = $clog2(D);
    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("dfpi_fifo depth must be a power of two");
    end

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr_ff;
    logic [AW:0]  rd_ptr_ff;
    logic         push;
    logic         pop;

    assign level     = wr_ptr_ff - rd_ptr_ff;
    assign in_ready  = (level != D[AW:0] ? 1'b1 : 1'b0) && !level[AW];
    assign out_valid = (wr_ptr_ff != rd_ptr_ff);
    assign out_data  = mem[rd_ptr_ff[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage is left without reset; only the pointers matter
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
        end
    end

endmodule : dfpi_fifo

module dfpi_top #(
    parameter int SAMPLE_W   = 16,
    parameter int RESULT_W   = 24,
    parameter int FIFO_DEPTH = 16,
    parameter int RATE_W     = 10
) (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Sample source
    input  wire logic [SAMPLE_W-1:0] sample_in_bus,
    // Start pins
    input  wire logic                async_start_n,
    input  wire logic                sync_start_n,
    output logic                     start_pulse_out_n,
    // Result pins
    input  wire logic                upper_byte_select,
    input  wire logic                lower_output_enable_n,
    input  wire logic                upper_output_enable_n,
    output logic      [RESULT_W-1:0] result_out_bus,
    output logic      [RESULT_W-1:0] result_out_oe,
    output logic                     data_ready
);
    localparam int ACC_W  = `DFPI_ACC_W;
    localparam int W0     = `DFPI_W0_BIT;
    localparam int LVL_W  = $clog2(FIFO_DEPTH) + 1;
    localparam int SMP_MIN_CYC =
        (`DFPI_PCLK_HZ + `DFPI_SAMPLE_MAX_HZ - 1) / `DFPI_SAMPLE_MAX_HZ;
    localparam logic [15:0] SMP_MIN_DIV = 16'(SMP_MIN_CYC - 1);

    if (SAMPLE_W != 16 || RESULT_W != 24 || RATE_W > 16 || RATE_W < 1)
    begin : g_bad_param
        $error("dfpi_top serves 16-bit samples and 24-bit results only");
    end
    if (`DFPI_PCLK_HZ > `DFPI_TAP_MAX_HZ) begin : g_bad_clock
        $error("dfpi_top: pclk exceeds the tap filter rate limit");
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [4:0] pin_raw;
    logic [4:0] pin_meta_ff;
    logic [4:0] pin_sync_ff;
    logic [SAMPLE_W-1:0] sample_meta_ff;
    logic [SAMPLE_W-1:0] sample_sync_ff;

    assign pin_raw = {upper_output_enable_n, lower_output_enable_n,
                      upper_byte_select, sync_start_n, async_start_n};

    for (genvar i = 0; i < 5; i++) begin : g_pin_sync
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pin_meta_ff[i] <= 1'b1;
                pin_sync_ff[i] <= 1'b1;
            end else begin
                pin_meta_ff[i] <= pin_raw[i];
                pin_sync_ff[i] <= pin_meta_ff[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_meta_ff <= '0;
            sample_sync_ff <= '0;
        end else begin
            sample_meta_ff <= sample_in_bus;
            sample_sync_ff <= sample_meta_ff;
        end
    end

    // ****************************************************************
    // Control registers over APB
    // ****************************************************************
    logic [15:0] filter_ctl_ff;
    logic [15:0] coef_word_ff;
    logic [15:0] decim_stage_ff;
    logic [15:0] decim_rate_ff;
    logic [15:0] sample_div_ff;
    logic        overrun_ff;
    logic        wr_en;
    logic        rd_setup;
    logic        addr_ok;
    logic [31:0] nxt_prdata;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;
    logic        overrun_set;
    logic [LVL_W-1:0] fifo_level;
    dfpi_pkg::dfpi_run_t run_ff;

    logic tap_dis;
    logic tap_byp;
    logic [`DFPI_STAGE_W-1:0] stages;
    logic [RATE_W-1:0]        rate;

    assign tap_dis = filter_ctl_ff[`DFPI_FDIS_BIT];
    assign tap_byp = filter_ctl_ff[`DFPI_FBYP_BIT];
    assign stages  = decim_stage_ff[`DFPI_STAGE_W-1:0];
    assign rate    = decim_rate_ff[RATE_W-1:0];

    assign addr_ok  = (paddr[1:0] == 2'h0) &&
                      (paddr <= `DFPI_OFF_STATUS);
    assign wr_en    = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filter_ctl_ff  <= `DFPI_FILTER_CTL_RST;
            coef_word_ff   <= `DFPI_CTL_ZERO_RST;
            decim_stage_ff <= `DFPI_CTL_ZERO_RST;
            decim_rate_ff  <= `DFPI_CTL_ZERO_RST;
            sample_div_ff  <= SMP_MIN_DIV;
        end else if (wr_en && paddr <= `DFPI_OFF_CTL_LAST) begin
            unique case (paddr[3:2])
                `DFPI_IDX_FILTER_CTL:  filter_ctl_ff  <= pwdata[15:0];
                `DFPI_IDX_COEF_WORD:   coef_word_ff   <= pwdata[15:0];
                `DFPI_IDX_DECIM_STAGE: decim_stage_ff <= pwdata[15:0];
                `DFPI_IDX_DECIM_RATE:  decim_rate_ff  <= pwdata[15:0];
            endcase
        end else if (wr_en && paddr == `DFPI_OFF_SAMPLE_DIV) begin
            // Floor keeps the sample rate under its limit
            sample_div_ff <= (pwdata[15:0] < SMP_MIN_DIV) ?
                             SMP_MIN_DIV : pwdata[15:0];
        end
    end

    // Overrun is sticky; a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_ff <= 1'b0;
        end else if (overrun_set) begin
            overrun_ff <= 1'b1;
        end else if (wr_en && paddr == `DFPI_OFF_STATUS &&
                     pwdata[`DFPI_STAT_OVR_BIT]) begin
            overrun_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        unique case (paddr)
            8'h00: nxt_prdata[15:0] = filter_ctl_ff;
            8'h04: nxt_prdata[15:0] = coef_word_ff;
            8'h08: nxt_prdata[15:0] = decim_stage_ff;
            8'h0C: nxt_prdata[15:0] = decim_rate_ff;
            `DFPI_OFF_SAMPLE_DIV: nxt_prdata[15:0] = sample_div_ff;
            `DFPI_OFF_STATUS: begin
                nxt_prdata[`DFPI_STAT_RUN_BIT] = (run_ff == dfpi_pkg::ST_RUN);
                nxt_prdata[`DFPI_STAT_OVR_BIT] = overrun_ff;
                nxt_prdata[`DFPI_STAT_LVL_LSB +: LVL_W] = fifo_level;
            end
            default: nxt_prdata = 32'h0000_0000;
        endcase
    end

    // Read data and error are prepared in the setup cycle; zero wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (rd_setup) begin
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= !addr_ok;
        end
    end

    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff && psel && penable;
    assign pready  = 1'b1;

    // ****************************************************************
    // Sample enable divider and start logic
    // ****************************************************************
    logic [15:0] div_cnt_ff;
    logic        sample_en;
    logic        astart_q_ff;
    logic        astart_prev_ff;
    logic        sstart_q_ff;
    logic        sstart_prev_ff;
    logic        astart_fall;
    logic        sstart_fall;
    logic        start_evt;
    logic        start_out_n_ff;

    assign sample_en = (div_cnt_ff == 16'h0000);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_ff <= 16'h0000;
        end else if (sample_en) begin
            div_cnt_ff <= sample_div_ff;
        end else begin
            div_cnt_ff <= div_cnt_ff - 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            astart_q_ff    <= 1'b1;
            astart_prev_ff <= 1'b1;
            sstart_q_ff    <= 1'b1;
            sstart_prev_ff <= 1'b1;
        end else if (sample_en) begin
            astart_q_ff    <= pin_sync_ff[dfpi_pkg::PIN_ASTART];
            astart_prev_ff <= astart_q_ff;
            sstart_q_ff    <= pin_sync_ff[dfpi_pkg::PIN_SSTART];
            sstart_prev_ff <= sstart_q_ff;
        end
    end

    assign astart_fall = astart_prev_ff && !astart_q_ff;
    assign sstart_fall = sstart_prev_ff && !sstart_q_ff;
    assign start_evt   = astart_fall || sstart_fall;

    // Low for one whole sample period so partner devices see it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_out_n_ff <= 1'b1;
        end else if (sample_en) begin
            start_out_n_ff <= !astart_fall;
        end
    end
    assign start_pulse_out_n = start_out_n_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff <= dfpi_pkg::ST_IDLE;
        end else begin
            unique case (run_ff)
                dfpi_pkg::ST_IDLE:
                    if (sample_en && start_evt) begin
                        run_ff <= dfpi_pkg::ST_RUN;
                    end
                dfpi_pkg::ST_RUN: run_ff <= dfpi_pkg::ST_RUN;
            endcase
        end
    end

    // ****************************************************************
    // Coarse decimator (arithmetic reduced to one integrate-and-dump)
    // ****************************************************************
    logic [SAMPLE_W-1:0] sample_cap_ff;
    logic [ACC_W-1:0]    acc_ff;
    logic [ACC_W-1:0]    acc_add;
    logic [ACC_W-1:0]    acc_sum;
    logic [RATE_W-1:0]   dec_cnt_ff;
    logic [ACC_W-1:0]    dump_data_ff;
    logic                dump_val_ff;
    logic                fifo_in_ready;
    logic                blocked;
    logic                at_rate;
    logic                dump_due;
    logic                running;

    assign running  = (run_ff == dfpi_pkg::ST_RUN);
    assign acc_add  = {{(ACC_W - W0 - 1){sample_cap_ff[SAMPLE_W-1]}},
                       sample_cap_ff, {(W0 + 1 - SAMPLE_W){1'b0}}};
    assign acc_sum  = (stages == '0) ? acc_add : acc_ff + acc_add;
    assign blocked  = dump_val_ff && !fifo_in_ready;
    assign at_rate  = (dec_cnt_ff == rate);
    assign dump_due = sample_en && running && at_rate && !blocked;
    assign overrun_set = sample_en && running && at_rate && blocked;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_cap_ff <= '0;
        end else if (sample_en) begin
            sample_cap_ff <= sample_sync_ff;
        end
    end

    // A full FIFO stalls the dump; samples keep integrating meanwhile
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff     <= '0;
            dec_cnt_ff <= '0;
        end else if (sample_en && running) begin
            acc_ff <= dump_due ? '0 : acc_sum;
            if (dump_due) begin
                dec_cnt_ff <= '0;
            end else if (!at_rate) begin
                dec_cnt_ff <= dec_cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dump_val_ff  <= 1'b0;
            dump_data_ff <= '0;
        end else if (dump_due) begin
            dump_val_ff  <= 1'b1;
            dump_data_ff <= acc_sum;
        end else if (fifo_in_ready) begin
            dump_val_ff  <= 1'b0;
        end
    end

    // ****************************************************************
    // Result FIFO, tap filter stage and output pins
    // ****************************************************************
    logic             fifo_out_valid;
    logic             fifo_out_ready;
    logic [ACC_W-1:0] fifo_out_data;
    logic [ACC_W-1:0] result_word_ff;
    logic             pop;
    logic             rdy_pre_ff;
    logic             data_ready_ff;
    logic [RESULT_W-1:0] nxt_out;
    logic [RESULT_W-1:0] out_bus_ff;

    dfpi_fifo #(
        .W (ACC_W),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (dump_val_ff),
        .in_ready  (fifo_in_ready),
        .in_data   (dump_data_ff),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    // A disabled tap filter drains nothing, so the FIFO fills
    assign fifo_out_ready = !tap_dis;
    assign pop = fifo_out_valid && fifo_out_ready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_word_ff <= '0;
            rdy_pre_ff     <= 1'b0;
            data_ready_ff  <= 1'b0;
        end else begin
            if (pop) begin
                result_word_ff <= fifo_out_data;
            end
            rdy_pre_ff    <= pop;
            data_ready_ff <= rdy_pre_ff;
        end
    end

    always_comb begin
        nxt_out[15:0] = tap_byp ? result_word_ff[W0-16:W0-31]
                                : result_word_ff[W0:W0-15];
        nxt_out[23:16] = pin_sync_ff[dfpi_pkg::PIN_USEL] ?
                         result_word_ff[W0+8:W0+1] :
                         result_word_ff[W0-16:W0-23];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_bus_ff <= '0;
        end else begin
            out_bus_ff <= nxt_out;
        end
    end

    assign result_out_bus = out_bus_ff;
    assign data_ready     = data_ready_ff;
    assign result_out_oe  = {{8{!pin_sync_ff[dfpi_pkg::PIN_UOEN]}},
                             {16{!pin_sync_ff[dfpi_pkg::PIN_LOEN]}}};

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    start_hold_a: assert property (
        !start_pulse_out_n && !sample_en |=> !start_pulse_out_n)
        else $error("start pulse ended before a sample period");
    start_end_a: assert property (
        !start_pulse_out_n && sample_en |=> start_pulse_out_n)
        else $error("start pulse longer than a sample period");
    run_start_a: assert property (
        !running && sample_en && sstart_fall |=> running)
        else $error("falling start did not begin operation");
    idle_decim_a: assert property (
        !running |-> dec_cnt_ff == '0 && !dump_val_ff)
        else $error("decimation active before start");
    ready_strobe_a: assert property (
        pop |-> ##2 data_ready && result_out_bus == $past(nxt_out, 1))
        else $error("result strobe not two cycles after pop");
    lower_map_a: assert property (
        rdy_pre_ff && !tap_byp |=> result_out_bus[15:0] ==
            $past(result_word_ff[W0:W0-15]))
        else $error("lower result bits mis-weighted");
    upper_map_a: assert property (
        rdy_pre_ff && pin_sync_ff[dfpi_pkg::PIN_USEL] |=>
            result_out_bus[23:16] == $past(result_word_ff[W0+8:W0+1]))
        else $error("upper result byte mis-selected");
    // Synchronisers hold their reset level for two edges after release
    lower_oe_a: assert property (
        $past(presetn, 1) && $past(presetn, 2) |->
            $past(lower_output_enable_n, 2) == !result_out_oe[0])
        else $error("lower enable does not follow pin");
    upper_oe_a: assert property (
        $past(presetn, 1) && $past(presetn, 2) |->
            $past(upper_output_enable_n, 2) == !result_out_oe[23])
        else $error("upper enable does not follow pin");
    stage_write_a: assert property (
        wr_en && paddr == 8'h08 |=> decim_stage_ff == $past(pwdata[15:0]))
        else $error("stage register write lost");
    capture_a: assert property (
        sample_en |=> sample_cap_ff == $past(sample_sync_ff))
        else $error("sample not captured on enable");

    start_c:   cover property (running && !$past(running));
    dump_c:    cover property (dump_due);
    overrun_c: cover property (overrun_set);
    ready_c:   cover property (data_ready);

endmodule : dfpi_top

// >>> test/dfpi_src_model.sv
/* Sample source model: an odd-step sweep, once per pclk, so the sign
   bit of the samples toggles often.
   Assumes the bench's pclk and presetn. */
module dfpi_src_model (
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Sample bus
    output logic [15:0] sample_in_bus
);
    timeunit 1ns;
    timeprecision 1ns;
    // Synchronous source, new value after each rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sample_in_bus <= 16'h0000;
        else sample_in_bus <= sample_in_bus + 16'h1235;
    end
endmodule : dfpi_src_model

// >>> test/dfpi_top_tb_top.sv
/* Bench of dfpi_top: registers, start pulse, enables, FIFO fill/drain.
   Assumes dfpi_src_model feeds the sample bus. */
module dfpi_top_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, spo_n, drdy, p;
    logic        as_n = 1, ss_n = 1, usel = 0, loe_n = 1, uoe_n = 1;
    logic [15:0] smp;
    logic [23:0] rbus, oe;
    int          fail_count = 0, compares = 0, cyc = 0, n, k;
    always #20 pclk = ~pclk;
    dfpi_src_model i_dfpi_src_model (.pclk, .presetn, .sample_in_bus(smp));
    dfpi_top i_dfpi_top (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .sample_in_bus(smp),
        .async_start_n(as_n), .sync_start_n(ss_n),
        .start_pulse_out_n(spo_n), .upper_byte_select(usel),
        .lower_output_enable_n(loe_n), .upper_output_enable_n(uoe_n),
        .result_out_bus(rbus), .result_out_oe(oe), .data_ready(drdy));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input logic [31:0] g, e, input string m);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask : chk
    // Idle edge first, so release and next setup never share a step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input string m);
        apb(0, a, 0);
        chk(rd, e, m);
    endtask : rchk
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done;
        end
    end
    // ****************
    // Tests
    // ****************
    initial begin
        void'($urandom(5));
        repeat (20) @(posedge pclk);
        presetn <= 1;
        rchk(8'h00, 32'h1, "ctl rst");
        rchk(8'h08, 32'h0, "stage rst");
        rchk(8'h0C, 32'h0, "rate rst");
        rchk(8'h14, 32'h0, "idle rst");
        apb(0, 8'h18, 0);
        chk(err, 1, "unmapped");
        for (k = 0; k < 4; k++) begin
            n = $urandom;
            usel <= n[20];
            apb(1, 8'h08, n);
            rchk(8'h08, n & 32'hFFFF, "stage wr");
            apb(1, 8'h0C, n);
            rchk(8'h0C, n & 32'hFFFF, "rate wr");
        end
        $display("regs done");
        apb(1, 8'h0C, 0);
        apb(1, 8'h08, 0);
        apb(1, 8'h10, 1);
        as_n <= 0;
        for (k = 0; k < 20 && spo_n !== 1'b0; k++) @(posedge pclk);
        n = 0;
        while (spo_n === 1'b0 && n < 9) begin
            n++;
            @(posedge pclk);
        end
        chk(n, 2, "pulse width");
        apb(0, 8'h14, 0);
        chk(rd[0], 1, "running");
        $display("start done");
        loe_n <= 0;
        repeat (3) @(posedge pclk);
        chk(oe, 24'h00FFFF, "low oe");
        loe_n <= 1;
        uoe_n <= 0;
        repeat (3) @(posedge pclk);
        chk(oe, 24'hFF0000, "up oe");
        $display("oe done");
        // Tap filter still disabled, so the FIFO fills and refuses
        usel <= 1;
        repeat (60) @(posedge pclk);
        rchk(8'h14, 32'h1003, "fifo full");
        apb(1, 8'h00, 0);
        n = 0;
        for (k = 0; k < 200; k++) begin
            @(posedge pclk);
            // Stage count 0: upper byte is the sign of bit 15
            if (drdy === 1'b1) begin
                n++;
                chk(rbus[23:16], {8{rbus[15]}}, "upper map");
            end
        end
        chk(n >= 16, 1, "drain");
        $display("fifo done");
        // Mid-run reset, then a start from the synchronous pin
        as_n <= 1;
        usel <= 0;
        presetn <= 0;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        rchk(8'h00, 32'h1, "ctl rst2");
        rchk(8'h14, 32'h0, "idle rst2");
        apb(1, 8'h00, 2);
        ss_n <= 0;
        n = 0;
        p = 0;
        for (k = 0; k < 40; k++) begin
            @(posedge pclk);
            if (spo_n !== 1'b1) p = 1;
            if (drdy === 1'b1) begin
                n++;
                chk(rbus, 24'h0, "bypass map");
            end
        end
        chk(p, 0, "no pulse");
        apb(0, 8'h14, 0);
        chk(rd[0], 1, "sync run");
        chk(n >= 8, 1, "bypass drain");
        $display("sync done");
        test_done;
    end
endmodule : dfpi_top_tb_top
